//--- rtl/locr_pkg.sv
// Constants for the lane output conditioning register slice
// Behaviour
// - Idle-auto bit 5 low lets bit 4 govern muting; high means automatic idle detect.
// - Manual idle: bit 4 low drives output, presence detect off; high mutes output.
// - Rate-auto bit 1 low uses bit 0 for rate range; high detects rate automatically.
// - Seven-bit swing code: 03h 600mV reset, 07h, 0Fh, 1Fh; 3Fh reserved.
// - De-emphasis bit 7 picks compatibility or enhanced type; bits 6:0 carry level.
// - De-emphasis byte 01h, E8h, 88h, 90h, A0h give 0 to -12 dB.
// - Global two-bit adjust scales all lanes: -25, -12.5, 0 (reset), +12.5 percent.
package locr_pkg;
	localparam logic [7:0] ADDR_IDLE_RATE = 8'h40;
	localparam logic [7:0] ADDR_SWING = 8'h42;
	localparam logic [7:0] ADDR_DEEMPH = 8'h43;
	localparam logic [7:0] ADDR_GLOBAL = 8'h47;
	localparam logic [7:0] RST_IDLE_RATE = 8'h00;
	localparam logic [7:0] RST_SWING = 8'h03;
	localparam logic [7:0] RST_DEEMPH = 8'h03;
	localparam logic [7:0] RST_GLOBAL = 8'h02;
	// Writable bit masks; reserved bits store nothing and read zero
	localparam logic [7:0] MASK_IDLE_RATE = 8'h33;
	localparam logic [7:0] MASK_SWING = 8'h7F;
	localparam logic [7:0] MASK_DEEMPH = 8'hFF;
	localparam logic [7:0] MASK_GLOBAL = 8'h03;
	localparam int BIT_IDLE_AUTO = 5;
	localparam int BIT_IDLE_SEL = 4;
	localparam int BIT_RATE_AUTO = 1;
	localparam int BIT_RATE_SEL = 0;
	localparam int BIT_DEEMPH_TYPE = 7;
	localparam logic [6:0] SWING_RESERVED = 7'h3F;
	typedef enum logic [2:0] {
		LOCR_SWING_600,
		LOCR_SWING_800,
		LOCR_SWING_1000,
		LOCR_SWING_1200,
		LOCR_SWING_OTHER
	} locr_swing_type;
	typedef enum logic [2:0] {
		LOCR_DE_0DB,
		LOCR_DE_3P5DB,
		LOCR_DE_6DB,
		LOCR_DE_9DB,
		LOCR_DE_12DB,
		LOCR_DE_OTHER
	} locr_deemph_type;
endpackage

//--- rtl/locr_regs.sv
// Register slice for the port B second lane output conditioning
`timescale 1ns/10ps
module locr_regs
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Management register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Lane controls
	output logic idle_auto,
	output logic output_muted,
	output logic signal_presence_detect_en,
	output logic rate_auto,
	output logic rate_high,
	output logic [6:0] output_swing_level,
	output logic output_swing_reserved,
	output logic deemphasis_enhanced,
	output logic [6:0] deemphasis_level,
	output logic [7:0] deemphasis_setting,
	output logic [1:0] global_swing_adjust
);
	typedef struct packed {
		logic [7:0] idle_rate;
		logic [7:0] swing;
		logic [7:0] deemph;
		logic [7:0] glob;
		logic [7:0] rdata;
		logic idle_auto;
		logic muted;
		logic sd_en;
		logic rate_auto;
		logic rate_high;
		logic swing_rsv;
	} locr_state_type;

	locr_state_type state_reg;
	locr_state_type state_next;

	function automatic logic [7:0] locr_merge(input logic [7:0] mask, input logic [7:0] data);
		locr_merge = data & mask;
	endfunction

	// Only four addresses are backed by storage; the rest of the map reads zero
	function automatic logic locr_mapped(input logic [7:0] addr);
		case (addr)
			locr_pkg::ADDR_IDLE_RATE,
			locr_pkg::ADDR_SWING,
			locr_pkg::ADDR_DEEMPH,
			locr_pkg::ADDR_GLOBAL: locr_mapped = 1'b1;
			default: locr_mapped = 1'b0;
		endcase
	endfunction

	always_comb
	begin
		state_next = state_reg;
		if (reg_write)
		begin
			case (reg_addr)
				locr_pkg::ADDR_IDLE_RATE: state_next.idle_rate = locr_merge(locr_pkg::MASK_IDLE_RATE, reg_wdata);
				locr_pkg::ADDR_SWING: state_next.swing = locr_merge(locr_pkg::MASK_SWING, reg_wdata);
				locr_pkg::ADDR_DEEMPH: state_next.deemph = locr_merge(locr_pkg::MASK_DEEMPH, reg_wdata);
				locr_pkg::ADDR_GLOBAL: state_next.glob = locr_merge(locr_pkg::MASK_GLOBAL, reg_wdata);
				default: state_next.glob = state_reg.glob;
			endcase
		end
		// Read data is registered; unmapped addresses answer zero
		if (reg_read)
		begin
			case (reg_addr)
				locr_pkg::ADDR_IDLE_RATE: state_next.rdata = state_reg.idle_rate;
				locr_pkg::ADDR_SWING: state_next.rdata = state_reg.swing;
				locr_pkg::ADDR_DEEMPH: state_next.rdata = state_reg.deemph;
				locr_pkg::ADDR_GLOBAL: state_next.rdata = state_reg.glob;
				default: state_next.rdata = 8'h00;
			endcase
		end
		// Decoded controls follow the stored values one cycle later
		state_next.idle_auto = state_reg.idle_rate[locr_pkg::BIT_IDLE_AUTO];
		// Under automatic idle the analog detector owns muting, so no forced mute here
		state_next.muted = !state_reg.idle_rate[locr_pkg::BIT_IDLE_AUTO]
			&& state_reg.idle_rate[locr_pkg::BIT_IDLE_SEL];
		state_next.sd_en = state_reg.idle_rate[locr_pkg::BIT_IDLE_AUTO];
		state_next.rate_auto = state_reg.idle_rate[locr_pkg::BIT_RATE_AUTO];
		state_next.rate_high = state_reg.idle_rate[locr_pkg::BIT_RATE_SEL];
		state_next.swing_rsv = state_reg.swing[6:0] == locr_pkg::SWING_RESERVED;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			// Decoded bits start low so the lane wakes driving at the low rate range
			state_reg <= '{
				idle_rate: locr_pkg::RST_IDLE_RATE,
				swing: locr_pkg::RST_SWING,
				deemph: locr_pkg::RST_DEEMPH,
				glob: locr_pkg::RST_GLOBAL,
				rdata: 8'h00,
				idle_auto: 1'b0,
				muted: 1'b0,
				sd_en: 1'b0,
				rate_auto: 1'b0,
				rate_high: 1'b0,
				swing_rsv: 1'b0
			};
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign idle_auto = state_reg.idle_auto;
	assign output_muted = state_reg.muted;
	assign signal_presence_detect_en = state_reg.sd_en;
	assign rate_auto = state_reg.rate_auto;
	assign rate_high = state_reg.rate_high;
	assign output_swing_level = state_reg.swing[6:0];
	assign output_swing_reserved = state_reg.swing_rsv;
	assign deemphasis_enhanced = state_reg.deemph[locr_pkg::BIT_DEEMPH_TYPE];
	assign deemphasis_level = state_reg.deemph[6:0];
	assign deemphasis_setting = state_reg.deemph;
	assign global_swing_adjust = state_reg.glob[1:0];


	// Idle and rate decode lag a write by two cycles
	a_manual_mute: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_IDLE_RATE && !reg_wdata[locr_pkg::BIT_IDLE_AUTO]
		&& reg_wdata[locr_pkg::BIT_IDLE_SEL] |-> ##2 output_muted)
		else $error("manual mute not applied");
	a_manual_drive: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_IDLE_RATE && !reg_wdata[locr_pkg::BIT_IDLE_AUTO]
		&& !reg_wdata[locr_pkg::BIT_IDLE_SEL] |-> ##2 !output_muted && !signal_presence_detect_en)
		else $error("manual drive not applied");
	a_auto_idle: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_IDLE_RATE && reg_wdata[locr_pkg::BIT_IDLE_AUTO]
		|-> ##2 idle_auto && !output_muted)
		else $error("auto idle not honoured");
	a_presence_auto: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_IDLE_RATE && reg_wdata[locr_pkg::BIT_IDLE_AUTO]
		|-> ##2 signal_presence_detect_en)
		else $error("presence detect not enabled");
	a_rate_select: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_IDLE_RATE
		|-> ##2 rate_high == $past(reg_wdata[locr_pkg::BIT_RATE_SEL], 2)
		&& rate_auto == $past(reg_wdata[locr_pkg::BIT_RATE_AUTO], 2)) else $error("rate controls wrong");

	// Stored fields follow a write one cycle later
	a_swing_write: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_SWING
		|=> output_swing_level == $past(reg_wdata[6:0]))
		else $error("swing not stored");
	a_swing_read: assert property (@(posedge clk) disable iff (!resetn)
		reg_read && !reg_write && reg_addr == locr_pkg::ADDR_SWING
		|=> reg_rdata == {1'b0, output_swing_level})
		else $error("swing read wrong");
	a_deemph_type: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_DEEMPH
		|=> deemphasis_enhanced == $past(reg_wdata[locr_pkg::BIT_DEEMPH_TYPE]))
		else $error("type bit not stored");
	a_deemph_level: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_DEEMPH
		|=> deemphasis_level == $past(reg_wdata[6:0]))
		else $error("level not stored");
	a_deemph_write: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_DEEMPH
		|=> deemphasis_setting == $past(reg_wdata))
		else $error("de-emphasis not stored");
	a_global_write: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_GLOBAL
		|=> global_swing_adjust == $past(reg_wdata[1:0]))
		else $error("global adjust not stored");
	a_global_read: assert property (@(posedge clk) disable iff (!resetn)
		reg_read && !reg_write && reg_addr == locr_pkg::ADDR_GLOBAL
		|=> reg_rdata == {6'h00, global_swing_adjust})
		else $error("global read wrong");

	// Reserved code is flagged, never refused
	a_swing_rsv: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_SWING && reg_wdata[6:0] == locr_pkg::SWING_RESERVED
		|-> ##2 output_swing_reserved)
		else $error("reserved code not flagged");
	a_swing_legal: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && reg_addr == locr_pkg::ADDR_SWING && reg_wdata[6:0] != locr_pkg::SWING_RESERVED
		|-> ##2 !output_swing_reserved)
		else $error("legal code flagged");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
		reg_read && reg_addr == locr_pkg::ADDR_IDLE_RATE
		|=> (reg_rdata & ~locr_pkg::MASK_IDLE_RATE) == 8'h00)
		else $error("reserved bits read back");

	// Holes in the map and idle cycles
	a_unmapped_read: assert property (@(posedge clk) disable iff (!resetn)
		reg_read && !locr_mapped(reg_addr)
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_unmapped_write: assert property (@(posedge clk) disable iff (!resetn)
		reg_write && !locr_mapped(reg_addr)
		|=> $stable(output_swing_level) && $stable(deemphasis_setting) && $stable(global_swing_adjust))
		else $error("unmapped write disturbed storage");
	a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
		!reg_read
		|=> $stable(reg_rdata))
		else $error("read data not held");
endmodule

//--- tb/locr_host_model.sv
// Host model that reaches the register slice through its parallel port
`timescale 1ns/10ps
module locr_host_model
(
	// Clock and read data
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	// Register requests
	output logic [7:0] reg_addr,
	output logic reg_write,
	output logic [7:0] reg_wdata,
	output logic reg_read
);
	initial
	begin
		reg_addr = 8'h00;
		reg_write = 1'h0;
		reg_wdata = 8'h00;
		reg_read = 1'h0;
	end
	// Callers keep reserved bits zero; only the flag test sends the reserved swing code
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clk);
		reg_write <= 1'h0;
		// Released data is scrambled so a stale byte cannot pass for a new one
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge clk);
		reg_read <= 1'h0;
		@(posedge clk);
		#1;
		d = reg_rdata;
	endtask
endmodule

//--- tb/lane_output_conditioning_regs_tb_top.sv
// Self-checking bench for the lane output conditioning register slice
`timescale 1ns/10ps
module lane_output_conditioning_regs_tb_top;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] v;} locr_row_type;
	logic clk, resetn, reg_write, reg_read, idle_auto, output_muted, sd_en, rate_auto;
	logic rate_high, output_swing_reserved, deemphasis_enhanced;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, deemphasis_setting, rd;
	logic [6:0] output_swing_level, deemphasis_level;
	logic [1:0] global_swing_adjust;
	int n_fail = 0;
	int tests_run = 0;
	locr_row_type rows [18] = '{'{8'h40, 8'h10, 8'h08}, '{8'h40, 8'h00, 8'h00},
		'{8'h40, 8'h20, 8'h14}, '{8'h40, 8'h30, 8'h14}, '{8'h40, 8'h03, 8'h03},
		'{8'h40, 8'h01, 8'h01}, '{8'h42, 8'h07, 8'h07}, '{8'h42, 8'h0F, 8'h0F},
		'{8'h42, 8'h1F, 8'h1F}, '{8'h43, 8'h01, 8'h01}, '{8'h43, 8'hE8, 8'hE8},
		'{8'h43, 8'h88, 8'h88}, '{8'h43, 8'h90, 8'h90}, '{8'h43, 8'hA0, 8'hA0},
		'{8'h47, 8'h00, 8'h00}, '{8'h47, 8'h01, 8'h01}, '{8'h47, 8'h03, 8'h03},
		'{8'h47, 8'h02, 8'h02}};
	logic [7:0] rst_a [4] = '{8'h40, 8'h42, 8'h43, 8'h47};
	logic [7:0] rst_v [4] = '{8'h00, 8'h03, 8'h03, 8'h02};
	locr_host_model i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read));
	locr_regs i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_write(reg_write),
		.reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.idle_auto(idle_auto), .output_muted(output_muted),
		.signal_presence_detect_en(sd_en), .rate_auto(rate_auto), .rate_high(rate_high),
		.output_swing_level(output_swing_level), .output_swing_reserved(output_swing_reserved),
		.deemphasis_enhanced(deemphasis_enhanced), .deemphasis_level(deemphasis_level),
		.deemphasis_setting(deemphasis_setting), .global_swing_adjust(global_swing_adjust));
	// Decoded outputs packed per register so one table column covers them
	function automatic logic [7:0] view(input logic [7:0] a);
		case (a)
			8'h40: view = {3'h0, idle_auto, output_muted, sd_en, rate_auto, rate_high};
			8'h42: view = {output_swing_reserved, output_swing_level};
			8'h43: view = {deemphasis_enhanced, deemphasis_level};
			default: view = {6'h00, global_swing_adjust};
		endcase
	endfunction
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic close_out;
		if (n_fail == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#100000;
		n_fail++;
		close_out;
	end
	initial
	begin
		resetn = 1'h0;
		repeat (3) @(posedge clk);
		resetn <= 1'h1;
		foreach (rows[i])
		begin
			i_host.wr(rows[i].a, rows[i].d);
			i_host.rd(rows[i].a, rd);
			chk("readback", rd, rows[i].d);
			chk("decoded", view(rows[i].a), rows[i].v);
			if (rows[i].a == 8'h43)
				chk("deemph byte", deemphasis_setting, rows[i].d);
		end
		// Second reset in mid-run must restore every default
		@(posedge clk);
		resetn <= 1'h0;
		@(posedge clk);
		resetn <= 1'h1;
		foreach (rst_a[i])
		begin
			i_host.rd(rst_a[i], rd);
			chk("reset value", rd, rst_v[i]);
			chk("reset decode", view(rst_a[i]), rst_v[i]);
		end
		// A hole in the map must neither store nor disturb neighbours
		i_host.wr(8'h41, 8'h55);
		i_host.rd(8'h41, rd);
		chk("unmapped", rd, 8'h00);
		i_host.rd(8'h42, rd);
		chk("neighbour", rd, 8'h03);
		// Reserved swing code is stored and flagged rather than refused
		i_host.wr(8'h42, 8'h3F);
		i_host.rd(8'h42, rd);
		chk("reserved swing", rd, 8'h3F);
		chk("reserved flag", view(8'h42), 8'hBF);
		close_out;
	end
endmodule
